// ===== shared/pad_port_consts.vh
// Register offsets, field layout and reset values of the six-bit pad port
`ifndef PAD_PORT_CONSTS_VH
`define PAD_PORT_CONSTS_VH

// Printed offsets are not all multiples of four: they are register indices
`define PIN_DATA_IDX 16'hf268
`define PIN_DIR_IDX 16'hf269
`define PAD_CFG_LOW_IDX 16'hf26a
`define PAD_CFG_HIGH_IDX 16'hf26b
// Byte address is four times the index
`define PIN_DATA_ADDR 18'h3c9a0
`define PIN_DIR_ADDR 18'h3c9a4
`define PAD_CFG_LOW_ADDR 18'h3c9a8
`define PAD_CFG_HIGH_ADDR 18'h3c9ac
`define ADDR_DECODE_BITS 18

`define PIN_COUNT 6
`define REG_WIDTH 8
`define PIN_DATA_RESET 6'h00
`define PIN_DIR_RESET 6'h00
`define PAD_CFG_LOW_RESET 6'h00
`define PAD_CFG_HIGH_RESET 6'h00

// Pad codes {high bit, low bit}
`define PAD_CODE_HIZ 2'h0
`define PAD_CODE_PCH 2'h1
`define PAD_CODE_NCH 2'h2
`define PAD_CODE_CMOS 2'h3

// Pin direction encodings
`define DIR_OUTPUT 1'h0
`define DIR_INPUT 1'h1

// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0

`endif

// ===== design/pad_cell_ctrl.v
// One pin's pad driver and pull control
`timescale 1ns/1ps
`include "pad_port_consts.vh"

module pad_cell_ctrl (
  // Configuration
  input wire i_dir,
  input wire [1:0] i_code,
  input wire i_data,
  // Pad controls
  output reg o_pin_out,
  output reg o_pin_oe,
  output reg o_pull_up,
  output reg o_pull_down
);

  always @* begin
    o_pin_out = 1'b0;
    o_pin_oe = 1'b0;
    o_pull_up = 1'b0;
    o_pull_down = 1'b0;
    if (i_dir == `DIR_OUTPUT) begin
      o_pin_out = i_data;
      case (i_code)
        `PAD_CODE_HIZ: o_pin_oe = 1'b0;
        `PAD_CODE_PCH: o_pin_oe = i_data;
        `PAD_CODE_NCH: o_pin_oe = ~i_data;
        `PAD_CODE_CMOS: o_pin_oe = 1'b1;
        default: o_pin_oe = 1'b0;
      endcase
    end else begin
      case (i_code)
        `PAD_CODE_PCH: o_pull_down = 1'b1;
        `PAD_CODE_NCH: o_pull_up = 1'b1;
        default: o_pull_up = 1'b0;
      endcase
    end
  end

endmodule

// ===== design/six_bit_port_pad_control.v
// Six-bit port with per-pin direction and pad style, AHB-Lite registers
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pad_port_consts.vh"

module six_bit_port_pad_control (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // Pins
  input wire [5:0] i_pin,
  output wire [5:0] o_pin,
  output wire [5:0] o_pin_oe,
  output wire [5:0] o_pull_up,
  output wire [5:0] o_pull_down
);

  // ==========================================================
  // Register state
  reg [5:0] pin_data_register_reg;
  reg [5:0] pin_direction_register_reg;
  reg [5:0] pad_config_low_bits_reg;
  reg [5:0] pad_config_high_bits_reg;
  reg [31:0] rdata_reg;
  reg [5:0] pin_sync1_reg;
  reg [5:0] pin_sync2_reg;

  reg wr_pend_reg;
  reg [1:0] wr_sel_reg;

  // ==========================================================
  // Pin input synchroniser
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_sync1_reg <= 6'h00;
      pin_sync2_reg <= 6'h00;
    end else begin
      pin_sync1_reg <= i_pin;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // ==========================================================
  // Address decode
  wire addr_phase = i_hsel & i_hready & (i_htrans == `HTRANS_NONSEQ);
  wire [17:0] addr = i_haddr[17:0];
  reg hit;
  reg [1:0] sel;
  always @* begin
    hit = 1'b1;
    sel = 2'h0;
    case (addr)
      `PIN_DATA_ADDR: sel = 2'h0;
      `PIN_DIR_ADDR: sel = 2'h1;
      `PAD_CFG_LOW_ADDR: sel = 2'h2;
      `PAD_CFG_HIGH_ADDR: sel = 2'h3;
      default: hit = 1'b0;
    endcase
  end

  // Data read mixes stored value and live pin level per direction
  wire [5:0] data_view = (pin_direction_register_reg & pin_sync2_reg) |
    (~pin_direction_register_reg & pin_data_register_reg);

  reg [5:0] read_mux;
  always @* begin
    case (sel)
      2'h0: read_mux = data_view;
      2'h1: read_mux = pin_direction_register_reg;
      2'h2: read_mux = pad_config_low_bits_reg;
      2'h3: read_mux = pad_config_high_bits_reg;
      default: read_mux = 6'h00;
    endcase
  end

  // ==========================================================
  // Bus phases; zero wait states, unmapped reads zero, writes dropped
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_phase & i_hwrite & hit;
      if (addr_phase) begin
        wr_sel_reg <= sel;
        if (!i_hwrite && hit) begin
          rdata_reg <= {26'h0000000, read_mux};
        end else begin
          rdata_reg <= 32'h00000000;
        end
      end
    end
  end

  // Writes land in the data phase; only the low six bits stored
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_data_register_reg <= `PIN_DATA_RESET;
      pin_direction_register_reg <= `PIN_DIR_RESET;
      pad_config_low_bits_reg <= `PAD_CFG_LOW_RESET;
      pad_config_high_bits_reg <= `PAD_CFG_HIGH_RESET;
    end else if (wr_pend_reg) begin
      case (wr_sel_reg)
        2'h0: pin_data_register_reg <= i_hwdata[5:0];
        2'h1: pin_direction_register_reg <= i_hwdata[5:0];
        2'h2: pad_config_low_bits_reg <= i_hwdata[5:0];
        2'h3: pad_config_high_bits_reg <= i_hwdata[5:0];
        default: pin_data_register_reg <= pin_data_register_reg;
      endcase
    end
  end

  assign o_hrdata = rdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = `HRESP_OKAY;

  // ==========================================================
  // Pad cells, one per pin
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : pad
      pad_cell_ctrl u_cell (
        .i_dir(pin_direction_register_reg[g]),
        .i_code({pad_config_high_bits_reg[g],
                 pad_config_low_bits_reg[g]}),
        .i_data(pin_data_register_reg[g]),
        .o_pin_out(o_pin[g]),
        .o_pin_oe(o_pin_oe[g]),
        .o_pull_up(o_pull_up[g]),
        .o_pull_down(o_pull_down[g])
      );
    end
  endgenerate

endmodule

// ===== tb/pad_port_monitor.sv
// Bus and pad checker of the six-bit port
`timescale 1ns/1ps
// ====
// Checker
module pad_port_monitor (
  input logic i_clk, i_reset_n, i_hsel, i_hwrite, i_hready,
  input logic o_hreadyout, o_hresp,
  input logic [1:0] i_htrans,
  input logic [2:0] i_hsize,
  input logic [31:0] i_haddr, i_hwdata, o_hrdata,
  input logic [5:0] i_pin, o_pin, o_pin_oe, o_pull_up, o_pull_down
);
  wire take = i_hsel && i_hready && i_htrans == 2'h2;
  wire [5:0] pull = o_pull_up | o_pull_down;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_zero_wait: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer wrong");
  a_pull_single: assert property (!(|(o_pull_up & o_pull_down)))
    else $error("both pulls on");
  a_pull_undriven: assert property (!(|(pull & o_pin_oe)))
    else $error("pull while driving");
  a_reset_quiet: assert property ($rose(i_reset_n) |->
    o_pin_oe == 6'h00 && pull == 6'h00) else $error("pin active at reset");
  a_high_zero: assert property (o_hrdata[31:6] == 26'h0)
    else $error("read bits set");
  a_rdata_hold: assert property (!take |=> $stable(o_hrdata))
    else $error("read data moved");
  a_pads_by_write: assert property (
    $changed({o_pin, o_pin_oe, pull}) |-> $past(take && i_hwrite, 2))
    else $error("pads moved unasked");
  a_unmapped_zero: assert property (take && !i_hwrite &&
    i_haddr[17:4] != 14'h3c9a |=> o_hrdata == 32'h0) else $error("hole read");
endmodule
bind six_bit_port_pad_control pad_port_monitor mon_u (.*);

// ===== tb/pin_board_model.sv
// Board side of the six port pins
`timescale 1ns/1ps
// ====
// Board
module pin_board_model (
  input logic i_clk,
  input logic [5:0] i_drive_en, i_drive_val, i_out, i_oe, i_up, i_dn,
  output logic [5:0] o_level
);
  logic [5:0] float_reg = 6'h15;
  // Open pins wander, so a stale level never reads as valid
  always @(posedge i_clk) float_reg <= ~float_reg;
  always_comb
    for (int i = 0; i < 6; i++)
      o_level[i] = i_oe[i] ? i_out[i] : i_drive_en[i] ? i_drive_val[i] :
        i_up[i] ? 1'b1 : i_dn[i] ? 1'b0 : float_reg[i];
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the six-bit pad port
`timescale 1ns/1ps
`include "pad_port_consts.vh"
// ====
// Bench
module testbench;
  logic i_clk = 0, i_reset_n = 0, i_hsel = 0, i_hwrite = 0, o_hreadyout;
  logic o_hresp;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd;
  logic [5:0] i_pin, o_pin, o_pin_oe, o_pull_up, o_pull_down, en = 6'h00;
  int mismatches = 0, check_count = 0;
  // dir, data, external drive, oe, pull up, pull down, data read
  logic [5:0] rows [5][7] = '{'{6'h00, 6'h3f, 6'h00, 6'h1a, 6'h00, 6'h00,
    6'h3f}, '{6'h00, 6'h00, 6'h00, 6'h2c, 6'h00, 6'h00, 6'h00},
    '{6'h3f, 6'h00, 6'h3f, 6'h00, 6'h24, 6'h12, 6'h15},
    '{6'h3f, 6'h2a, 6'h09, 6'h00, 6'h24, 6'h12, 6'h25},
    '{6'h07, 6'h3f, 6'h07, 6'h18, 6'h04, 6'h02, 6'h3d}};
  always #12.5 i_clk = ~i_clk;
  six_bit_port_pad_control dut_u (.*, .i_hsize(3'h2), .i_hready(o_hreadyout));
  pin_board_model board_u (.i_clk(i_clk), .i_drive_en(en),
    .i_drive_val(6'h15), .i_out(o_pin), .i_oe(o_pin_oe), .i_up(o_pull_up),
    .i_dn(o_pull_down), .o_level(i_pin));
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n = 0;
    i_hsel <= 1'b1;
    i_htrans <= `HTRANS_NONSEQ;
    i_haddr <= a;
    i_hwrite <= w;
    do begin @(posedge i_clk); n++; end while (o_hreadyout !== 1'b1 && n < 50);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do begin @(posedge i_clk); n++; end while (o_hreadyout !== 1'b1 && n < 50);
    rd = o_hrdata;
    if (n >= 50) begin
      mismatches++;
      end_of_test;
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    check(o_pin_oe | o_pull_up | o_pull_down, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, `PIN_DATA_ADDR + 4 * i, 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b1, `PAD_CFG_LOW_ADDR, 32'hffffffff);
    bus(1'b1, 32'h3c9b0, 32'hffffffff);
    bus(1'b0, `PAD_CFG_LOW_ADDR, 32'h0);
    check(rd, 32'h3f);
    bus(1'b0, 32'h3c9b0, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `PAD_CFG_LOW_ADDR, 32'h1a);
    bus(1'b1, `PAD_CFG_HIGH_ADDR, 32'h2c);
    foreach (rows[r]) begin
      bus(1'b1, `PIN_DIR_ADDR, rows[r][0]);
      bus(1'b1, `PIN_DATA_ADDR, rows[r][1]);
      en <= rows[r][2];
      // Two sync flops plus margin before the pins are read
      repeat (4) @(posedge i_clk);
      check(o_pin_oe, rows[r][3]);
      check(o_pull_up, rows[r][4]);
      check(o_pull_down, rows[r][5]);
      check(o_pin & ~rows[r][0], rows[r][1] & ~rows[r][0]);
      bus(1'b0, `PIN_DATA_ADDR, 32'h0);
      check(rd, rows[r][6]);
    end
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    check(o_pin_oe | o_pull_up | o_pull_down, 32'h0);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    bus(1'b0, `PAD_CFG_HIGH_ADDR, 32'h0);
    check(rd, 32'h0);
    end_of_test;
  end
endmodule
